// ### hw/adcc_top.sv
// Converter control block with AXI4-Lite register access
// Functional notes
// R1 - Conversion starts only after start bit goes low, high, then low again
// R2 - Converter held in reset while start bit is high
// R3 - Busy flag in bit 6 is read only, high during conversion
// R4 - Busy flag set once the start pulse completes
// R5 - Busy flag cleared when the conversion finishes
// R6 - Enable bit 5 powers converter; software sets it before starting
// R7 - Result registers keep their contents while converter is disabled
// R8 - Format 0: result 11..4 high, 3..0 low
// R9 - Format 1: result 11..8 high, 7..0 low
// R10 - Control 0 bits 3..0 read as zero
// R11 - Control 1: channel 7..5, reference 4..3, clock 2..0, all writable
// R12 - New result written no later than the cycle busy clears
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [adcc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [adcc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog core
  output logic core_reset,
  output logic core_start,
  input wire logic core_done,
  input wire logic [adcc_pkg::RES_W-1:0] core_data,
  output logic [2:0] channel_sel,
  output logic [1:0] reference_sel,
  output logic [2:0] conv_clock_sel,
  // Interrupt
  output logic irq
);
  import adcc_pkg::*;

  function automatic adcc_reg_e reg_decode(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CTRL0: reg_decode = ADCC_R_CTRL0;
      OFS_CTRL1: reg_decode = ADCC_R_CTRL1;
      OFS_RES_HIGH: reg_decode = ADCC_R_HIGH;
      OFS_RES_LOW: reg_decode = ADCC_R_LOW;
      OFS_INT_STAT: reg_decode = ADCC_R_STAT;
      OFS_INT_CLR: reg_decode = ADCC_R_CLR;
      OFS_INT_EN: reg_decode = ADCC_R_EN;
      default: reg_decode = ADCC_R_NONE;
    endcase
  endfunction

  // Register state
  logic start_bit;
  logic start_prev;
  logic conv_busy_flag;
  logic converter_enable;
  logic result_format_select;
  logic [7:0] adc_control_1;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_en;
  // Bus state
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic w_lane0;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [1:0] rresp;
  logic [DATA_W-1:0] rdata;
  logic [ADDR_W-1:0] rd_addr;
  logic start_req;

  adcc_res_if rif ();

  adcc_result_regs u_res (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .rif(rif)
  );

  // Write channel decode
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic wr_do = ce && aw_held && w_held && !bvalid;
  wire adcc_reg_e wr_sel = reg_decode(aw_addr);
  wire logic wr_hit = wr_do && w_lane0;
  wire logic wr_ctrl0 = wr_hit && wr_sel == ADCC_R_CTRL0;
  wire logic wr_ctrl1 = wr_hit && wr_sel == ADCC_R_CTRL1;
  wire logic wr_clr = wr_hit && wr_sel == ADCC_R_CLR;
  wire logic wr_en = wr_hit && wr_sel == ADCC_R_EN;
  wire logic wr_bad = wr_sel == ADCC_R_NONE || wr_sel == ADCC_R_HIGH
                      || wr_sel == ADCC_R_LOW || wr_sel == ADCC_R_STAT;
  // Read channel decode
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire adcc_reg_e rd_sel = reg_decode(s_axi_araddr);
  wire logic [7:0] ctrl0_view = {start_bit, conv_busy_flag, converter_enable,
                                 result_format_select, 4'h0}; // R10 R3

  // Conversion sequencing
  // Falling start edge completes the pulse; a rising edge alone starts nothing
  wire logic start_fire = start_prev && !start_bit; // R1
  wire logic conv_ok = start_fire && converter_enable; // R6
  // Start high or enable low aborts whatever is running
  wire logic conv_abort = conv_busy_flag && (start_bit || !converter_enable);
  wire logic conv_end = conv_busy_flag && core_done && !conv_abort;
  wire logic [INT_W-1:0] int_event = {conv_abort, conv_end};
  wire logic [INT_W-1:0] int_clear = wr_clr ? w_data[INT_W-1:0] : {INT_W{1'b0}};
  wire logic [INT_W-1:0] next_int_stat = (int_stat & ~int_clear) | int_event;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_bit <= RST_CTRL0[BIT_START];
      converter_enable <= RST_CTRL0[BIT_ENABLE];
      result_format_select <= RST_CTRL0[BIT_FORMAT];
      adc_control_1 <= RST_CTRL1;
    end else if (ce) begin
      if (wr_ctrl0) begin
        start_bit <= w_data[BIT_START];
        converter_enable <= w_data[BIT_ENABLE];
        result_format_select <= w_data[BIT_FORMAT];
      end
      if (wr_ctrl1) begin
        adc_control_1 <= w_data[7:0]; // R11
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_prev <= 1'b0;
      conv_busy_flag <= 1'b0;
      start_req <= 1'b0;
    end else if (ce) begin
      start_prev <= start_bit;
      start_req <= conv_ok; // R1
      if (conv_ok) begin
        conv_busy_flag <= 1'b1; // R4
      end else if (conv_end || conv_abort) begin
        conv_busy_flag <= 1'b0; // R5
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_stat <= {INT_W{1'b0}};
      int_en <= {INT_W{1'b0}};
    end else if (ce) begin
      // Event set wins over a clear in the same cycle
      int_stat <= next_int_stat;
      if (wr_en) begin
        int_en <= w_data[INT_W-1:0];
      end
    end
  end

  // Result handed over in the very cycle busy clears
  assign rif.load = conv_end; // R12
  assign rif.enable = converter_enable; // R7
  assign rif.format = result_format_select;
  assign rif.data = core_data;

  assign core_reset = start_bit || !converter_enable; // R2 R6
  assign core_start = start_req;
  assign channel_sel = adc_control_1[CH_LSB +: 3]; // R11
  assign reference_sel = adc_control_1[REF_LSB +: 2];
  assign conv_clock_sel = adc_control_1[CLK_LSB +: 3];
  assign irq = |(int_stat & int_en);

  // AXI write path: address and data taken in either order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && s_axi_bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ce && !aw_held && !bvalid;
  assign s_axi_wready = ce && !w_held && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  // AXI read path: one cycle from address to data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= '0;
      rd_addr <= '0;
    end else if (ce) begin
      if (ar_take) begin
        rvalid <= 1'b1;
        rd_addr <= s_axi_araddr;
        rresp <= (rd_sel == ADCC_R_NONE || rd_sel == ADCC_R_CLR) ? RESP_SLVERR : RESP_OKAY;
        case (rd_sel)
          ADCC_R_CTRL0: rdata <= {24'h0, ctrl0_view};
          ADCC_R_CTRL1: rdata <= {24'h0, adc_control_1};
          ADCC_R_HIGH: rdata <= {24'h0, rif.high};
          ADCC_R_LOW: rdata <= {24'h0, rif.low};
          ADCC_R_STAT: rdata <= {30'h0, int_stat};
          ADCC_R_EN: rdata <= {30'h0, int_en};
          default: rdata <= '0;
        endcase
      end else if (rvalid && s_axi_rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = ce && !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  chk_start_seq: assert property (@(posedge clk) disable iff (!nrst) // R1
    ce && $fell(start_bit) && converter_enable && $past(ce) |=> core_start)
    else $error("completed start pulse did not launch conversion");
  chk_no_early_start: assert property (@(posedge clk) disable iff (!nrst) // R1
    $rose(core_start) |-> !start_bit && $past(start_prev) && !$past(start_bit))
    else $error("conversion launched without full start pulse");
  chk_reset_hold: assert property (@(posedge clk) disable iff (!nrst) // R2
    start_bit |-> core_reset && !core_start)
    else $error("core not held in reset while start high");
  chk_busy_cause: assert property (@(posedge clk) disable iff (!nrst) // R3
    $rose(conv_busy_flag) |-> $past(conv_ok))
    else $error("busy set without a start");
  chk_busy_set: assert property (@(posedge clk) disable iff (!nrst) // R4
    ce && conv_ok |=> conv_busy_flag)
    else $error("busy not set after start pulse");
  chk_busy_clear: assert property (@(posedge clk) disable iff (!nrst) // R5
    ce && conv_end |=> !conv_busy_flag)
    else $error("busy not cleared at conversion end");
  chk_disable_off: assert property (@(posedge clk) disable iff (!nrst) // R6
    !converter_enable |-> core_reset ##1 (!core_start || converter_enable))
    else $error("disabled converter not held off");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (!nrst) // R10
    rvalid && reg_decode(rd_addr) == ADCC_R_CTRL0 |-> rdata[3:0] == 4'h0)
    else $error("reserved control bits read nonzero");
  chk_ctrl1_rw: assert property (@(posedge clk) disable iff (!nrst) // R11
    wr_ctrl1 |=> adc_control_1 == $past(w_data[7:0]) && channel_sel == $past(w_data[7:5]))
    else $error("control 1 write not stored");
  chk_result_by_busy: assert property (@(posedge clk) disable iff (!nrst) // R12
    ce && $past(ce) && $fell(conv_busy_flag) && !$past(conv_abort) && $past(converter_enable)
      |-> rif.high == ($past(result_format_select) ? {4'h0, $past(core_data[11:8])}
                                                   : $past(core_data[11:4])))
    else $error("result not updated when busy cleared");

  // Conversion and interrupt checks
  chk_done_sticky: assert property (@(posedge clk) disable iff (!nrst) // R5
    ce && conv_end |=> int_stat[IRQ_DONE])
    else $error("done event not recorded");
  chk_clear_done: assert property (@(posedge clk) disable iff (!nrst)
    wr_clr && w_data[IRQ_DONE] && !conv_end |=> !int_stat[IRQ_DONE])
    else $error("done status not cleared");
  chk_abort_sticky: assert property (@(posedge clk) disable iff (!nrst) // R2
    ce && conv_abort |=> int_stat[IRQ_ABORT] && !conv_busy_flag)
    else $error("abort not recorded");
  chk_enable_abort: assert property (@(posedge clk) disable iff (!nrst) // R6
    ce && conv_busy_flag && !converter_enable |=> !conv_busy_flag)
    else $error("busy kept while disabled");
  chk_start_once: assert property (@(posedge clk) disable iff (!nrst) // R1
    ce && core_start |=> !core_start)
    else $error("start pulse longer than one cycle");
  chk_busy_ro: assert property (@(posedge clk) disable iff (!nrst) // R3
    wr_ctrl0 && !conv_ok && !conv_end && !conv_abort |=> $stable(conv_busy_flag))
    else $error("busy flag changed by a write");
  chk_ctrl0_store: assert property (@(posedge clk) disable iff (!nrst) // R6
    wr_ctrl0 |=> start_bit == $past(w_data[BIT_START])
      && converter_enable == $past(w_data[BIT_ENABLE])
      && result_format_select == $past(w_data[BIT_FORMAT]))
    else $error("control 0 write not stored");
  chk_core_release: assert property (@(posedge clk) disable iff (!nrst) // R2 R6
    !core_reset |-> converter_enable && !start_bit)
    else $error("core released while held off");
  chk_idle_done: assert property (@(posedge clk) disable iff (!nrst)
    ce && core_done && !conv_busy_flag |=> $stable(rif.high) && $stable(rif.low))
    else $error("result loaded without a conversion");
  chk_irq_masked: assert property (@(posedge clk) disable iff (!nrst)
    int_en == '0 |-> !irq)
    else $error("masked interrupt raised");

  // Bus handshake and clock enable checks
  chk_bresp_hold: assert property (@(posedge clk) disable iff (!nrst)
    bvalid && !s_axi_bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_wr_refused: assert property (@(posedge clk) disable iff (!nrst)
    bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  chk_rdata_hold: assert property (@(posedge clk) disable iff (!nrst)
    rvalid && !s_axi_rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  chk_ar_refused: assert property (@(posedge clk) disable iff (!nrst)
    rvalid |-> !s_axi_arready)
    else $error("read accepted during data phase");
  chk_read_bad: assert property (@(posedge clk) disable iff (!nrst)
    ar_take && rd_sel == ADCC_R_NONE |=> rvalid && rresp == RESP_SLVERR && rdata == '0)
    else $error("unmapped read not refused");
  chk_ready_gated: assert property (@(posedge clk) disable iff (!nrst)
    !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("ready raised while frozen");
  chk_ce_freeze: assert property (@(posedge clk) disable iff (!nrst)
    !ce |=> $stable(conv_busy_flag) && $stable(start_bit) && $stable(int_stat) && $stable(bvalid))
    else $error("state moved while frozen");
endmodule // adcc_top

// ### hw/adcc_pkg.sv
// Package with register map, field positions and reset values for the converter control block
package adcc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W = 12;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_RES_HIGH = 8'h08;
  localparam logic [7:0] OFS_RES_LOW = 8'h0C;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_CLR = 8'h14;
  localparam logic [7:0] OFS_INT_EN = 8'h18;
  // Control 0 fields
  localparam int BIT_START = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_ENABLE = 5;
  localparam int BIT_FORMAT = 4;
  // Control 1 fields
  localparam int CH_LSB = 5;
  localparam int REF_LSB = 3;
  localparam int CLK_LSB = 0;
  // Reset values
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_RES = 8'h00;
  // Interrupt status bits
  localparam int INT_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ADCC_R_CTRL0 = 3'b000,
    ADCC_R_CTRL1 = 3'b001,
    ADCC_R_HIGH = 3'b010,
    ADCC_R_LOW = 3'b011,
    ADCC_R_STAT = 3'b100,
    ADCC_R_CLR = 3'b101,
    ADCC_R_EN = 3'b110,
    ADCC_R_NONE = 3'b111
  } adcc_reg_e;
endpackage

// ### hw/adcc_res_if.sv
// Interface between the control logic and the result register pair
`timescale 1ns/1ps
interface adcc_res_if;
  logic load;
  logic enable;
  logic format;
  logic [11:0] data;
  logic [7:0] high;
  logic [7:0] low;
  modport ctrl (output load, output enable, output format, output data, input high, input low);
  modport res (input load, input enable, input format, input data, output high, output low);
endinterface

// ### hw/adcc_result_regs.sv
// Result register pair with justification select
`timescale 1ns/1ps
module adcc_result_regs
  import adcc_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Result path
  adcc_res_if.res rif
);
  logic [7:0] high;
  logic [7:0] low;
  wire logic do_load = ce && rif.load && rif.enable;
  // Format 0: top eight bits high, low nibble at the bottom of low
  wire logic [7:0] next_high = rif.format ? {4'h0, rif.data[11:8]} : rif.data[11:4]; // R8 R9
  wire logic [7:0] next_low = rif.format ? rif.data[7:0] : {4'h0, rif.data[3:0]}; // R8 R9

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high <= RST_RES;
      low <= RST_RES;
    end else if (do_load) begin // R7
      high <= next_high;
      low <= next_low;
    end
  end

  assign rif.high = high;
  assign rif.low = low;

  chk_hold_disabled: assert property (@(posedge clk) disable iff (!nrst) // R7
    !rif.enable |=> $stable(high) && $stable(low))
    else $error("result changed while converter disabled");
  chk_fmt_left: assert property (@(posedge clk) disable iff (!nrst) // R8
    do_load && !rif.format |=> high == $past(rif.data[11:4]) && low == {4'h0, $past(rif.data[3:0])})
    else $error("left justified result misplaced");
  chk_fmt_right: assert property (@(posedge clk) disable iff (!nrst) // R9
    do_load && rif.format |=> high == {4'h0, $past(rif.data[11:8])} && low == $past(rif.data[7:0]))
    else $error("right justified result misplaced");
endmodule // adcc_result_regs

// ### tb/adcc_top_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adcc_top_tb;
  import adcc_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [31:0] wd;
    logic [1:0] br;
    logic [31:0] rd;
    logic [1:0] rr;
  } adcc_row_s;
  logic clk, nrst, ce, core_reset, core_start, core_done, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, reference_sel;
  logic [11:0] core_data;
  logic [2:0] channel_sel, conv_clock_sel;
  int n_fail = 0;
  int n_compared = 0;
  int n_start = 0;
  int cyc = 0;
  adcc_row_s rows [7];
  logic [7:0] ofs [6] = '{OFS_CTRL0, OFS_CTRL1, OFS_RES_HIGH, OFS_RES_LOW, OFS_INT_STAT, OFS_INT_EN};

  adcc_top dut (.clk(clk), .nrst(nrst), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .core_reset(core_reset),
    .core_start(core_start), .core_done(core_done), .core_data(core_data),
    .channel_sel(channel_sel), .reference_sel(reference_sel),
    .conv_clock_sel(conv_clock_sel), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts start pulses; also cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (core_start === 1'b1) n_start <= n_start + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic test_end(input string s);
    $display("test %s finished", s);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ta, tw, da, dw;
    da = 0;
    dw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Ready sampled mid-cycle, so the take edge is known before it comes
    while (!(da && dw)) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      r = s_axi_bresp;
    end while (s_axi_bvalid !== 1'b1);
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!t) begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
    end
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (s_axi_rvalid !== 1'b1);
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    wr(a, {24'h0, d}, rsp);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
    rd(a, rdv, rsp);
    chk(rdv, {24'h0, e}, m);
  endtask

  task automatic done_pulse(input logic [11:0] d);
    core_data <= d;
    core_done <= 1'b1;
    @(posedge clk);
    core_done <= 1'b0;
    core_data <= ~d;
  endtask

  task automatic reset_chk();
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    chk(core_reset, 1, "core not held in reset");
    chk(irq, 0, "irq during reset");
    nrst <= 1'b1;
    @(posedge clk);
    foreach (ofs[i]) rchk(ofs[i], 8'h00, "reset value");
    chk({channel_sel, reference_sel, conv_clock_sel}, 0, "reset selects");
    test_end("reset");
  endtask

  task automatic conv(input logic f, input logic [11:0] d);
    int k;
    k = n_start;
    wreg(OFS_CTRL0, {3'b101, f, 4'h0});
    chk(core_reset, 1, "core not held while start high");
    repeat (3) @(posedge clk);
    chk(n_start, k, "start while bit high");
    wreg(OFS_CTRL0, {3'b001, f, 4'h0});
    repeat (2) @(posedge clk);
    chk(n_start, k + 1, "start pulse count");
    rchk(OFS_CTRL0, {3'b011, f, 4'h0}, "busy not set");
    done_pulse(d);
    rchk(OFS_CTRL0, {3'b001, f, 4'h0}, "busy not cleared");
    rchk(OFS_RES_HIGH, f ? {4'h0, d[11:8]} : d[11:4], "result high");
    rchk(OFS_RES_LOW, f ? d[7:0] : {4'h0, d[3:0]}, "result low");
    test_end("conversion");
  endtask

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    core_done = 1'b0;
    core_data = 12'h000;
    rows[0] = '{OFS_CTRL1, 32'hB5, RESP_OKAY, 32'hB5, RESP_OKAY};
    rows[1] = '{OFS_CTRL0, 32'h5F, RESP_OKAY, 32'h10, RESP_OKAY};
    rows[2] = '{OFS_INT_EN, 32'h03, RESP_OKAY, 32'h03, RESP_OKAY};
    rows[3] = '{OFS_RES_HIGH, 32'hFF, RESP_SLVERR, 32'h00, RESP_OKAY};
    rows[4] = '{OFS_INT_STAT, 32'h03, RESP_SLVERR, 32'h00, RESP_OKAY};
    rows[5] = '{OFS_INT_CLR, 32'h01, RESP_OKAY, 32'h00, RESP_SLVERR};
    rows[6] = '{8'h1C, 32'h77, RESP_SLVERR, 32'h00, RESP_SLVERR};
    reset_chk();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd, rsp);
      chk(rsp, rows[i].br, "write response");
      rd(rows[i].a, rdv, rsp);
      chk(rdv, rows[i].rd, "read data");
      chk(rsp, rows[i].rr, "read response");
    end
    chk({channel_sel, reference_sel, conv_clock_sel}, 32'hB5, "select outputs");
    test_end("table");
    // Lane 0 strobe low stores nothing
    s_axi_wstrb <= 4'hE;
    wreg(OFS_CTRL1, 8'h00);
    s_axi_wstrb <= 4'hF;
    rchk(OFS_CTRL1, 8'hB5, "write without lane 0 stored");
    test_end("strobe");
    // Enable alone is no start pulse
    wreg(OFS_CTRL0, 8'h20);
    repeat (4) @(posedge clk);
    chk(n_start, 0, "start without pulse");
    chk(core_reset, 0, "core not released");
    test_end("no pulse");
    conv(1'b0, 12'hABC);
    chk(irq, 1, "done irq missing");
    rchk(OFS_INT_STAT, 8'h01, "done status");
    wreg(OFS_INT_CLR, 8'h01);
    chk(irq, 0, "irq not cleared");
    conv(1'b1, 12'h5E7);
    wreg(OFS_CTRL0, 8'h00);
    done_pulse(12'h321);
    rchk(OFS_RES_HIGH, 8'h05, "high changed while off");
    rchk(OFS_RES_LOW, 8'hE7, "low changed while off");
    wreg(OFS_CTRL0, 8'h80);
    wreg(OFS_CTRL0, 8'h00);
    repeat (3) @(posedge clk);
    chk(n_start, 2, "start while disabled");
    test_end("disabled");
    // Start raised again mid-conversion aborts it
    wreg(OFS_INT_CLR, 8'h03);
    wreg(OFS_INT_EN, 8'h02);
    wreg(OFS_CTRL0, 8'hA0);
    wreg(OFS_CTRL0, 8'h20);
    wreg(OFS_CTRL0, 8'hA0);
    rchk(OFS_CTRL0, 8'hA0, "busy after abort");
    rchk(OFS_INT_STAT, 8'h02, "abort status");
    chk(irq, 1, "abort irq missing");
    wreg(OFS_INT_EN, 8'h00);
    chk(irq, 0, "irq not masked");
    test_end("abort");
    // Clock enable low freezes a running conversion
    wreg(OFS_CTRL0, 8'h20);
    ce <= 1'b0;
    done_pulse(12'h123);
    chk(s_axi_awready | s_axi_arready, 0, "ready while frozen");
    ce <= 1'b1;
    rchk(OFS_CTRL0, 8'h60, "busy lost while frozen");
    done_pulse(12'h123);
    rchk(OFS_RES_HIGH, 8'h12, "result after freeze");
    rchk(OFS_CTRL0, 8'h20, "busy after freeze");
    test_end("freeze");
    reset_chk();
    give_verdict();
  end
endmodule // adcc_top_tb
